// >>> rtl/scb_pkg.sv
// Shared constants and carriers for the scaled counter with BCD output.
// Assumes a 125 MHz clock and a register port driven by a local master.
package scb_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_NS = 8;
   localparam int UPD_NS = 10000;
   localparam int PRN_NS = 2000;
   localparam int OSW_NS = 8000;
   localparam int UPD_CYC = UPD_NS / CLK_NS;
   localparam int PRN_CYC = (PRN_NS + CLK_NS - 1) / CLK_NS;
   localparam int OSW_CYC = OSW_NS / CLK_NS;
   localparam logic [15:0] OS_MAX_PULSES = 16'h0190;

   // ----------------------------------------
   // Register map and field positions
   // ----------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_RATIO = 8'h04;
   localparam logic [7:0] A_OFFSET = 8'h08;
   localparam logic [7:0] A_LOWER = 8'h0C;
   localparam logic [7:0] A_UPPER = 8'h10;
   localparam logic [7:0] A_STATUS = 8'h14;
   localparam logic [7:0] A_VALUE = 8'h18;
   localparam int CTRL_CLR_BIT = 7;
   localparam logic [6:0] CTRL_RST = 7'h10;

   // ----------------------------------------
   // Value ranges
   // ----------------------------------------
   localparam logic [19:0] RATIO_ONE = 20'hF4240;
   localparam logic [19:0] RATIO_MIN = 20'h00001;
   localparam logic signed [20:0] OFS_MAX = 21'sh0F423F;
   localparam logic [19:0] DISP_MAX = 20'hF423F;
   localparam logic [39:0] CNT_LIM = 40'hE8D4A50FFF;
   localparam logic [41:0] OVC_MAX = 42'h000_0098_967F;
   localparam logic signed [24:0] LIM_RST = 25'sh0000000;
   localparam logic [29:0] DEN_1 = 30'h000F4240;
   localparam logic [29:0] DEN_10 = 30'h00989680;
   localparam logic [29:0] DEN_100 = 30'h05F5E100;
   localparam logic [29:0] DEN_1000 = 30'h3B9ACA00;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef enum logic [1:0] {MULT_X1, MULT_X2, MULT_X4, MULT_RSV} scb_mult_t;

   typedef struct packed {
      logic judge_en;
      logic neg_logic;
      logic two_phase;
      logic [1:0] div_sel;
      scb_mult_t mult_sel;
   } scb_ctrl_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } scb_bus_t;

   typedef struct packed {
      logic plus;
      logic minus;
      logic [23:0] digit;
   } scb_bcd_t;

   typedef struct packed {
      logic lower;
      logic good;
      logic upper;
   } scb_judge_t;

endpackage

// >>> rtl/scb_top.sv
// Counter value path: scaling, error detection and parallel BCD port.
// Pulse events come from an upstream sensor decoder, one per cycle at most;
// hold and clear inputs are already synchronous to clk_i.
`timescale 1ns/10ps

// What this block does
// - Count is pulses, multiplier, ratio, divider, plus offset
// - Multiplier x1/x2/x4 only for two-phase sensor
// - Ratio accepted from 1 down to 0.000001
// - Divider is 1, 1/10, 1/100 or 1/1000
// - Signed offset magnitude up to 999999
// - Overflow error when scaled value exceeds 999999
// - Overflow error past internal limit 999999999999
// - Six parallel BCD digits, positive logic default
// - Plus line for zero/positive, minus for negative
// - BCD logic sense selectable to negative
// - Exactly one judgment line, sense independent
// - Error output on whenever any error exists
// - Overspeed error on excessive pulse rate
// - Overcount beyond 9999999 flags, count restarts zero
// - Hold low freezes the BCD data and print strobe, not the count
// - Clear low zeroes count while held low
// - Low print strobe on every BCD update
// - Reset request zeroes count and clears errors
module scb_top
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Register port
   input wire scb_pkg::scb_bus_t bus_i,
   output logic [31:0] rdata_o,
   // Sensor pulse events
   input wire logic pulse_i,
   input wire logic dir_i,
   // External control inputs
   input wire logic hold_n_i,
   input wire logic clear_n_i,
   // Parallel output port
   output scb_pkg::scb_bcd_t bcd_o,
   output scb_pkg::scb_judge_t judge_o,
   output logic error_o,
   output logic print_n_o
);
   import scb_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic wr_hit(input scb_bus_t b, input logic [7:0] a);
      wr_hit = b.wr && (b.addr == a);
   endfunction

   function automatic logic [23:0] bin2bcd(input logic [19:0] bin);
      logic [23:0] acc;
      acc = 24'h000000;
      for (int i = 19; i >= 0; i--)
      begin
         for (int d = 0; d < 6; d++)
         begin
            if (acc[d*4 +: 4] > 4'h4)
            begin
               acc[d*4 +: 4] = acc[d*4 +: 4] + 4'h3;
            end
         end
         acc = {acc[22:0], bin[i]};
      end
      bin2bcd = acc;
   endfunction

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   scb_ctrl_t ctrl, next_ctrl;
   logic [19:0] ratio, next_ratio;
   logic signed [20:0] offset, next_offset;
   logic signed [24:0] lower_lim, next_lower_lim;
   logic signed [24:0] upper_lim, next_upper_lim;
   logic [31:0] next_rdata;
   logic soft_clr;
   logic [3:0] err;
   logic signed [42:0] val;
   logic signed [31:0] wsig;

   always_comb
   begin
      wsig = signed'(bus_i.wdata);
      next_ctrl = ctrl;
      next_ratio = ratio;
      next_offset = offset;
      next_lower_lim = lower_lim;
      next_upper_lim = upper_lim;
      soft_clr = wr_hit(bus_i, A_CTRL) && bus_i.wdata[CTRL_CLR_BIT];
      if (wr_hit(bus_i, A_CTRL))
      begin
         next_ctrl = scb_ctrl_t'(bus_i.wdata[6:0]);
      end
      if (wr_hit(bus_i, A_RATIO))
      begin
         // Out of range ratios are pinned to the nearest legal end
         if (bus_i.wdata == 32'h00000000)
            next_ratio = RATIO_MIN;
         else if (bus_i.wdata > {12'h000, RATIO_ONE})
            next_ratio = RATIO_ONE;
         else
            next_ratio = bus_i.wdata[19:0];
      end
      if (wr_hit(bus_i, A_OFFSET))
      begin
         if (wsig > 32'(OFS_MAX))
            next_offset = OFS_MAX;
         else if (wsig < -32'(OFS_MAX))
            next_offset = -OFS_MAX;
         else
            next_offset = wsig[20:0];
      end
      if (wr_hit(bus_i, A_LOWER))
      begin
         next_lower_lim = wsig[24:0];
      end
      if (wr_hit(bus_i, A_UPPER))
      begin
         next_upper_lim = wsig[24:0];
      end
      next_rdata = 32'h00000000;
      if (bus_i.rd)
      begin
         case (bus_i.addr)
            A_CTRL: next_rdata = {25'h0000000, ctrl};
            A_RATIO: next_rdata = {12'h000, ratio};
            A_OFFSET: next_rdata = 32'(offset);
            A_LOWER: next_rdata = 32'(lower_lim);
            A_UPPER: next_rdata = 32'(upper_lim);
            A_STATUS: next_rdata = {27'h0000000, ~hold_n_i, err};
            A_VALUE: next_rdata = val[31:0];
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         ctrl <= scb_ctrl_t'(CTRL_RST);
         ratio <= RATIO_ONE;
         offset <= 21'sh000000;
         lower_lim <= LIM_RST;
         upper_lim <= LIM_RST;
         rdata_o <= 32'h00000000;
      end
      else
      begin
         ctrl <= next_ctrl;
         ratio <= next_ratio;
         offset <= next_offset;
         lower_lim <= next_lower_lim;
         upper_lim <= next_upper_lim;
         rdata_o <= next_rdata;
      end
   end

   // ----------------------------------------
   // Scaling and counting
   // ----------------------------------------
   logic signed [41:0] raw, next_raw, raw_try;
   logic [41:0] raw_mag, try_mag, val_mag;
   logic [59:0] prod;
   logic [40:0] scaled;
   logic [2:0] step;
   logic clr_req, ovc_now, ovd_now, ovi_now, osp_now;
   logic [3:0] set_vec, next_err;
   logic [15:0] os_cnt, next_os_cnt;
   logic [12:0] os_win, next_os_win;

   always_comb
   begin
      clr_req = ~clear_n_i | soft_clr;
      // Single phase sensors always count by one
      case (ctrl.two_phase ? ctrl.mult_sel : MULT_X1)
         MULT_X2: step = 3'h2;
         MULT_X4: step = 3'h4;
         default: step = 3'h1;
      endcase
      raw_mag = raw[41] ? 42'(-raw) : 42'(raw);
      prod = raw_mag[39:0] * ratio;
      case (ctrl.div_sel)
         2'h1: scaled = 41'(prod / DEN_10);
         2'h2: scaled = 41'(prod / DEN_100);
         2'h3: scaled = 41'(prod / DEN_1000);
         default: scaled = 41'(prod / DEN_1);
      endcase
      val = (raw[41] ? -43'(scaled) : 43'(scaled)) + 43'(offset);
      val_mag = val[42] ? 42'(-val) : val[41:0];
      ovd_now = val_mag > 42'(DISP_MAX);
      ovc_now = val_mag > OVC_MAX;
      raw_try = dir_i ? raw - 42'(step) : raw + 42'(step);
      try_mag = raw_try[41] ? 42'(-raw_try) : 42'(raw_try);
      ovi_now = pulse_i && (try_mag > 42'(CNT_LIM));
      // Rate check: pulses counted over a fixed window
      next_os_win = (os_win == 13'(OSW_CYC - 1)) ? 13'h0000 : os_win + 13'h0001;
      next_os_cnt = (os_win == 13'(OSW_CYC - 1)) ? 16'h0000 : os_cnt;
      osp_now = pulse_i && (os_cnt >= OS_MAX_PULSES);
      if (pulse_i && !osp_now)
      begin
         next_os_cnt = next_os_cnt + 16'h0001;
      end
      next_raw = raw;
      if (clr_req)
      begin
         next_raw = 42'sh00000000000;
      end
      else if (ovc_now)
      begin
         next_raw = 42'sh00000000000;
      end
      else if (pulse_i && !ovi_now)
      begin
         next_raw = raw_try;
      end
      set_vec = {ovc_now, osp_now, ovi_now, ovd_now};
      // New events win over a clear in the same cycle
      next_err = (err & {4{~clr_req}}) | set_vec;
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         raw <= 42'sh00000000000;
         err <= 4'h0;
         os_cnt <= 16'h0000;
         os_win <= 13'h0000;
      end
      else
      begin
         raw <= next_raw;
         err <= next_err;
         os_cnt <= next_os_cnt;
         os_win <= next_os_win;
      end
   end

   // ----------------------------------------
   // Output port
   // ----------------------------------------
   logic [12:0] upd_cnt, next_upd_cnt;
   logic [8:0] prn_cnt, next_prn_cnt;
   logic upd;
   scb_bcd_t next_bcd, fmt;
   scb_judge_t next_judge;

   always_comb
   begin
      next_upd_cnt = (upd_cnt == 13'(UPD_CYC - 1)) ? 13'h0000 : upd_cnt + 13'h0001;
      upd = (upd_cnt == 13'(UPD_CYC - 1)) && hold_n_i;
      // Overrange values show the largest legal reading
      fmt.digit = bin2bcd(ovd_now ? DISP_MAX : val_mag[19:0]);
      fmt.plus = ~val[42];
      fmt.minus = val[42];
      if (ctrl.neg_logic)
      begin
         fmt = ~fmt;
      end
      next_bcd = upd ? fmt : bcd_o;
      next_prn_cnt = upd ? 9'(PRN_CYC) : (prn_cnt != 9'h000 ? prn_cnt - 9'h001 : prn_cnt);
      next_judge = '0;
      if (ctrl.judge_en)
      begin
         // Judgment lines are never inverted by the logic sense
         next_judge.lower = val < 43'(lower_lim);
         next_judge.upper = !next_judge.lower && (val > 43'(upper_lim));
         next_judge.good = !next_judge.lower && !next_judge.upper;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         upd_cnt <= 13'h0000;
         prn_cnt <= 9'h000;
         bcd_o <= '0;
         judge_o <= '0;
         error_o <= 1'b0;
         print_n_o <= 1'b1;
      end
      else
      begin
         upd_cnt <= next_upd_cnt;
         prn_cnt <= next_prn_cnt;
         bcd_o <= next_bcd;
         judge_o <= next_judge;
         error_o <= |err;
         print_n_o <= (next_prn_cnt == 9'h000);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence print_low_s;
      !print_n_o [*8];
   endsequence

   clear_holds_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
      !clear_n_i |=> raw == 42'sh00000000000)
      else $error("count not zero after clear");
   hold_freezes_bcd_a: assert property (@(posedge clk_i) disable iff (reset_i)
      !hold_n_i |=> $stable(bcd_o))
      else $error("bcd data moved during hold");
   print_on_update_a: assert property (@(posedge clk_i) disable iff (reset_i)
      upd |=> print_low_s)
      else $error("print strobe missing after update");
   no_print_held_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (upd_cnt == 13'(UPD_CYC - 1)) && !hold_n_i |=> print_n_o)
      else $error("print strobe while held");
   error_follows_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (err != 4'h0) |=> error_o)
      else $error("error output not raised");
   judge_onehot_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ctrl.judge_en ##1 ctrl.judge_en |=> $onehot(judge_o))
      else $error("judgment not one-hot");
   clear_errors_a: assert property (@(posedge clk_i) disable iff (reset_i)
      clr_req && (set_vec == 4'h0) |=> err == 4'h0)
      else $error("errors kept after reset request");
   single_step_a: assert property (@(posedge clk_i) disable iff (reset_i)
      pulse_i && !ctrl.two_phase && !dir_i && !clr_req && !ovc_now && !ovi_now
      |=> raw == $past(raw) + 42'sh00000000001)
      else $error("single phase step not one");
   polarity_pos_a: assert property (@(posedge clk_i) disable iff (reset_i)
      upd && !ctrl.neg_logic |=> bcd_o.minus == $past(val[42]) && bcd_o.plus != bcd_o.minus)
      else $error("polarity lines wrong");
   overcount_wrap_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ovc_now |=> err[3] && raw == 42'sh00000000000)
      else $error("overcount not flagged or not wrapped");
   limit_overflow_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ovi_now && !clr_req && !ovc_now |=> err[1] && $stable(raw))
      else $error("internal limit overflow missed");

endmodule

// >>> tb/scb_recorder.sv
// Behavioural recorder on the far side of the parallel BCD port.
// Assumes port lines settle on the shared clock; bench commands hold and clear.
`timescale 1ns/10ps
module scb_recorder
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Bench commands
   input wire logic hold_req_i,
   input wire logic clear_req_i,
   // Port lines
   input wire scb_pkg::scb_bcd_t bcd_i,
   input wire logic print_n_i,
   output logic hold_n_o,
   output logic clear_n_o,
   // Captured data
   output scb_pkg::scb_bcd_t cap_o,
   output int strobes_o
);
   import scb_pkg::*;
   logic last_n;
   // Level lines, held low for as long as commanded
   assign hold_n_o = !hold_req_i;
   assign clear_n_o = !clear_req_i;
   // Data is taken on the falling strobe, as a printer would
   always_ff @(posedge clk_i)
   begin
      last_n <= reset_i ? 1'b1 : print_n_i;
      if (reset_i)
         strobes_o <= 0;
      else if (last_n && !print_n_i)
      begin
         strobes_o <= strobes_o + 1;
         cap_o <= bcd_i;
      end
   end
endmodule

// >>> tb/scb_top_bench.sv
// Self-checking bench for the scaled counter and its BCD port.
// Assumes the recorder model on the port and a local register master.
`timescale 1ns/10ps
module scb_top_bench;
   import scb_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   scb_bus_t bus = '0;
   logic pulse_i = 1'b0;
   logic dir_i = 1'b0;
   logic hold_req = 1'b0;
   logic clear_req = 1'b0;
   logic [31:0] rdata_o;
   scb_bcd_t bcd_o;
   scb_bcd_t cap;
   scb_judge_t judge_o;
   logic error_o;
   logic print_n_o;
   logic hold_n;
   logic clear_n;
   int strobes;
   int fail_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int exp_div[4] = '{15, -3, -5, -5};
   logic [31:0] d;
   always #4 clk_i = !clk_i;

   scb_top scb_top_i (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata_o),
      .pulse_i(pulse_i), .dir_i(dir_i), .hold_n_i(hold_n), .clear_n_i(clear_n),
      .bcd_o(bcd_o), .judge_o(judge_o), .error_o(error_o), .print_n_o(print_n_o));
   scb_recorder scb_recorder_i (.clk_i(clk_i), .reset_i(reset_i), .hold_req_i(hold_req),
      .clear_req_i(clear_req), .bcd_i(bcd_o), .print_n_i(print_n_o), .hold_n_o(hold_n),
      .clear_n_o(clear_n), .cap_o(cap), .strobes_o(strobes));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      bus <= '{1'b1, 1'b0, a, v};
      @(posedge clk_i);
      bus <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      bus <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk_i);
      bus <= '0;
      #1 chk(rdata_o, exp);
   endtask
   task automatic pulses(input int n, input logic dn);
      @(posedge clk_i);
      pulse_i <= 1'b1;
      dir_i <= dn;
      repeat (n) @(posedge clk_i);
      pulse_i <= 1'b0;
   endtask
   task automatic wait_strobe();
      int n0;
      n0 = strobes;
      for (int i = 0; i < 1400 && strobes == n0; i++)
         @(posedge clk_i);
      #1 chk(32'(strobes != n0), 32'h1);
   endtask
   task automatic settle();
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      #1 chk(bcd_o, 32'h0);
      chk(print_n_o, 32'h1);
      rd(A_CTRL, 32'h10);
      rd(A_RATIO, 32'h000F4240);
      rd(A_STATUS, 32'h0);
      rd(8'h1C, 32'h0);
      $display("test reset done");
      wr(A_CTRL, 32'h12);
      pulses(3, 1'b0);
      rd(A_VALUE, 32'hC);
      wr(A_CTRL, 32'h02);
      pulses(1, 1'b0);
      rd(A_VALUE, 32'hD);
      wr(A_CTRL, 32'h11);
      pulses(1, 1'b1);
      rd(A_VALUE, 32'hB);
      wr(A_CTRL, 32'h13);
      pulses(1, 1'b0);
      rd(A_VALUE, 32'hC);
      $display("test multiplier done");
      @(posedge clk_i);
      clear_req <= 1'b1;
      pulses(2, 1'b0);
      rd(A_VALUE, 32'h0);
      @(posedge clk_i);
      clear_req <= 1'b0;
      $display("test clear done");
      wr(A_RATIO, 32'h0007A120);
      wr(A_OFFSET, 32'hFFFFFFFB);
      rd(A_OFFSET, 32'hFFFFFFFB);
      wr(A_CTRL, 32'h10);
      pulses(40, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         wr(A_CTRL, 32'h10 | 32'(k << 2));
         rd(A_VALUE, 32'(exp_div[k]));
      end
      $display("test scaling done");
      wr(A_LOWER, 32'h0);
      wr(A_UPPER, 32'hA);
      wr(A_CTRL, 32'h54);
      settle();
      chk(judge_o, 32'h4);
      wr(A_OFFSET, 32'h5);
      settle();
      chk(judge_o, 32'h2);
      wr(A_OFFSET, 32'h14);
      settle();
      chk(judge_o, 32'h1);
      wr(A_OFFSET, 32'hFFFFFFFB);
      $display("test judgment done");
      wait_strobe();
      chk(cap, {6'h0, 1'b0, 1'b1, 24'h000003});
      wr(A_CTRL, 32'h74);
      wait_strobe();
      chk(cap, {6'h0, 1'b1, 1'b0, 24'hFFFFFC});
      chk(judge_o, 32'h4);
      wr(A_CTRL, 32'h54);
      $display("test bcd done");
      hold_req <= 1'b1;
      pulses(20, 1'b0);
      rd(A_VALUE, 32'hFFFFFFFE);
      rd(A_STATUS, 32'h10);
      d = 32'(strobes);
      repeat (1400) @(posedge clk_i);
      chk(32'(strobes), d);
      chk(cap, {6'h0, 1'b1, 1'b0, 24'hFFFFFC});
      hold_req <= 1'b0;
      wait_strobe();
      chk(cap, {6'h0, 1'b0, 1'b1, 24'h000002});
      $display("test hold done");
      wr(A_OFFSET, 32'h000F423F);
      settle();
      rd(A_STATUS, 32'h1);
      chk(error_o, 32'h1);
      wr(A_CTRL, 32'hD4);
      settle();
      // Overflow still live at the first request, so set wins over clear
      rd(A_STATUS, 32'h1);
      wr(A_CTRL, 32'hD4);
      settle();
      rd(A_STATUS, 32'h0);
      rd(A_VALUE, 32'h000F423F);
      chk(error_o, 32'h0);
      wr(A_OFFSET, 32'h0);
      pulses(900, 1'b0);
      settle();
      rd(A_STATUS, 32'h4);
      chk(error_o, 32'h1);
      @(posedge clk_i);
      clear_req <= 1'b1;
      settle();
      rd(A_STATUS, 32'h0);
      rd(A_VALUE, 32'h0);
      chk(error_o, 32'h0);
      @(posedge clk_i);
      clear_req <= 1'b0;
      $display("test errors done");
      tally_and_finish();
   end
endmodule
